// [design/wdu_pkg.sv]
// Purpose: shared constants and types for the watchdog unit
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   offsets of the four registers are local choices
package wdu_pkg;
	// register byte offsets
	localparam logic [3:0] WDU_OFS_CLOCK_CONFIG = 4'h0;
	localparam logic [3:0] WDU_OFS_CONTROL      = 4'h4;
	localparam logic [3:0] WDU_OFS_COMPARE      = 4'h8;
	localparam logic [3:0] WDU_OFS_PROTECTION   = 4'hc;
	// clock config field positions
	localparam int WDU_CLK_SRC_LSB   = 0;
	localparam int WDU_CLK_DIV_LSB   = 4;
	localparam int WDU_CLK_DEBUG_RUN_BIT = 8;
	// control field positions
	localparam int WDU_CTL_RUN_LSB   = 0;
	localparam int WDU_CTL_CLEAR_BIT = 4;
	localparam int WDU_CTL_STAT_BIT  = 8;
	localparam int WDU_CTL_MODE_LSB  = 9;
	// key values and reset values
	localparam logic [15:0] WDU_PROT_KEY      = 16'h0096;
	localparam logic [3:0]  WDU_RUN_STOP      = 4'ha;
	localparam logic [3:0]  WDU_RUN_READ_RUN  = 4'h0;
	localparam logic [9:0]  WDU_CMP_RESET     = 10'h3ff;
	localparam logic [1:0]  WDU_MODE_RESET    = 2'h0;
	localparam logic [1:0]  WDU_MODE_NMI      = 2'h1;
	localparam logic [1:0]  WDU_MODE_ESCALATE = 2'h2;
	// clock sources
	localparam logic [1:0]  WDU_SRC_INTERNAL_OSCILLATOR_INT  = 2'h0;
	localparam logic [1:0]  WDU_SRC_LS_XTAL   = 2'h1;
	localparam logic [1:0]  WDU_SRC_HS_OSC    = 2'h2;
	localparam logic [1:0]  WDU_SRC_EXT_IN    = 2'h3;
	// divider terminal counts (ratio minus one)
	localparam logic [13:0] WDU_DIV_BASE_M1   = 14'h07ff; // 1/2048
	localparam logic [13:0] WDU_DIV_LS_M1     = 14'h007f; // 1/128
	// sources fitted on this part; an unfitted source cannot be chosen
	localparam logic [3:0]  WDU_SRC_FITTED    = 4'hf;
	// axi responses
	localparam logic [1:0]  WDU_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  WDU_RESP_SLVERR   = 2'h2;
endpackage : wdu_pkg

// [design/wdu_divider.sv]
// Purpose: divides one source tick stream to a counter tick pulse
// Assumes: src_tick is a one-cycle pulse per source clock edge
// Notes:   terminal count may change any time; counter restarts when past it
`timescale 1ns/10ps
`default_nettype none
module wdu_divider
	import wdu_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        src_tick,
	input  wire logic        enable,
	input  wire logic [13:0] term_m1,
	output var  logic        div_tick
);
	// all divider state in one struct
	typedef struct packed {
		logic [13:0] cnt; // source edges seen
		logic        tick; // registered output pulse
	} wdu_div_state_t;

	wdu_div_state_t st_reg;
	wdu_div_state_t st_next;

	// count source ticks; gated off keeps the phase held
	always_comb
	begin
		st_next      = st_reg;
		st_next.tick = 1'b0;
		if (enable && src_tick)
		begin
			if (st_reg.cnt >= term_m1)
			begin
				st_next.cnt  = 14'h0000;
				st_next.tick = 1'b1;
			end
			else
			begin
				st_next.cnt = st_reg.cnt + 14'h0001;
			end
		end
	end

	// state register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign div_tick = st_reg.tick;
endmodule // wdu_divider
`default_nettype wire

// [design/wdu_counter.sv]
// Purpose: 10-bit timeout counter with compare match
// Assumes: tick is the divided counter clock enable
// Notes:   clear has priority over counting
`timescale 1ns/10ps
`default_nettype none
module wdu_counter
	import wdu_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       tick,
	input  wire logic       clear,
	input  wire logic [9:0] cmp,
	output var  logic [9:0] count,
	output var  logic       match
);
	// counter state
	typedef struct packed {
		logic [9:0] cnt;
		logic       match;
	} wdu_cnt_state_t;

	wdu_cnt_state_t st_reg;
	wdu_cnt_state_t st_next;

	// a match restarts at zero, giving cmp+1 ticks per period
	always_comb
	begin
		st_next       = st_reg;
		st_next.match = 1'b0;
		if (clear)
			st_next.cnt = 10'h000;
		else if (tick)
		begin
			if (st_reg.cnt == cmp)
			begin
				st_next.cnt   = 10'h000;
				st_next.match = 1'b1;
			end
			else
				st_next.cnt = st_reg.cnt + 10'h001;
		end
	end

	// state register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign count = st_reg.cnt;
	assign match = st_reg.match;

	a_match_wraps : assert property (@(posedge aclk) disable iff (!aresetn)
		match |-> count == 10'h000) else $error("counter not zero after match");
	a_hold_idle : assert property (@(posedge aclk) disable iff (!aresetn)
		!tick && !clear |=> count == $past(count)) else $error("counter moved");
endmodule // wdu_counter
`default_nettype wire

// [design/wdu_top.sv]
// Purpose: watchdog unit with nmi/reset output and AXI4-Lite registers
// Assumes: source tick inputs are one-cycle pulses synchronous to aclk
// Notes:   protected fields write only while the protection key is open
//
// Overview of operation
// - compare match issues nmi or reset per mode
// - match clears counter, counting continues
// - nmi sets interrupt status flag
// - status flag bit 8, read only
// - counter clear write resets counter and flag
// - after clear, full period restarts from zero; only the counter clears, the divider keeps its phase
// - mode 0 reset, 1 nmi, 3 reserved
// - mode 2 nmi, then reset if flag set
// - run field 0xa stops the watchdog
// - key 0x0096 opens protected fields
// - clock source select, unsupported not selectable
// - division 2048..16384, crystal 128, external 1
// - debug run bit gates clock in debug
// - counting continues during cpu halt
// - sleep counts only while source runs
// - other run values start; reads 0x0 or 0xa
// - compare resets to 0x3ff, compared continuously
// - period equals compare plus one ticks
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module wdu_top
	import wdu_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// source clock ticks, one pulse per source edge
	input  wire logic        internal_oscillator_tick,
	input  wire logic        low_speed_crystal_tick,
	input  wire logic        high_speed_oscillator_tick,
	input  wire logic        external_clock_input_tick,
	// cpu state
	input  wire logic        cpu_debug_mode,
	// events out
	output var  logic        nmi_pulse,
	output var  logic        system_reset_pulse
);
	// complete block state
	typedef struct packed {
		logic        aw_held;   // write address captured
		logic [3:0]  aw_addr;
		logic        w_held;    // write data captured
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        unlocked;  // protection key open
		logic        debug_run;
		logic [1:0]  div_sel;
		logic [1:0]  src_sel;
		logic [1:0]  mode;
		logic        stat_flag; // interrupt status flag
		logic        running;
		logic [9:0]  cmp;
		logic        nmi;
		logic        rst;
	} wdu_state_t;

	wdu_state_t st_reg;
	wdu_state_t st_next;

	logic        src_tick;   // tick of the chosen source
	logic [13:0] term_m1;    // divider terminal count
	logic        div_en;     // divider gate
	logic        cnt_tick;   // counter clock enable
	logic        cnt_clear;  // software counter clear
	logic        cnt_match;  // compare match pulse
	logic [9:0]  cnt_value;  // live counter value
	logic        wr_fire;    // both write halves present
	logic        prot_ok;    // protected write permitted
	logic [31:0] wval;       // write data masked by strobes

	// pick the source tick; sleep stop shows as missing ticks
	always_comb
	begin
		unique case (st_reg.src_sel)
			WDU_SRC_INTERNAL_OSCILLATOR_INT: src_tick = internal_oscillator_tick;
			WDU_SRC_LS_XTAL:  src_tick = low_speed_crystal_tick;
			WDU_SRC_HS_OSC:   src_tick = high_speed_oscillator_tick;
			WDU_SRC_EXT_IN:   src_tick = external_clock_input_tick;
		endcase
	end

	// ratio table; oscillators double per select step
	always_comb
	begin
		unique case (st_reg.src_sel)
			WDU_SRC_LS_XTAL: term_m1 = WDU_DIV_LS_M1;
			WDU_SRC_EXT_IN:  term_m1 = 14'h0000;
			default:         term_m1 = 14'((15'(WDU_DIV_BASE_M1) + 15'h1) << st_reg.div_sel) - 14'h1;
		endcase
	end

	// halt needs no input: halt never gates the count
	assign div_en = st_reg.running && (st_reg.debug_run || !cpu_debug_mode);

	wdu_divider u_divider (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.src_tick (src_tick),
		.enable   (div_en),
		.term_m1  (term_m1),
		.div_tick (cnt_tick)
	);

	wdu_counter u_counter (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (cnt_tick),
		.clear   (cnt_clear),
		.cmp     (st_reg.cmp),
		.count   (cnt_value),
		.match   (cnt_match)
	);

	assign wr_fire = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
	assign prot_ok = st_reg.unlocked;
	assign wval    = st_reg.w_data & {{8{st_reg.w_strb[3]}}, {8{st_reg.w_strb[2]}},
		{8{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};
	assign cnt_clear = wr_fire && prot_ok && st_reg.aw_addr == WDU_OFS_CONTROL
		&& st_reg.w_strb[0] && st_reg.w_data[WDU_CTL_CLEAR_BIT];

	// bus, registers and match response
	always_comb
	begin
		st_next     = st_reg;
		st_next.nmi = 1'b0;
		st_next.rst = 1'b0;
		// capture address and data in either order
		if (s_axi_awvalid && !st_reg.aw_held)
		begin
			st_next.aw_held = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.w_held)
		begin
			st_next.w_held = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		// response once both halves are held
		if (wr_fire)
		begin
			st_next.aw_held = 1'b0;
			st_next.w_held  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = WDU_RESP_OKAY;
			unique case (st_reg.aw_addr)
				WDU_OFS_PROTECTION:
				begin
					if (st_reg.w_strb[1:0] == 2'h3)
						st_next.unlocked = st_reg.w_data[15:0] == WDU_PROT_KEY;
				end
				WDU_OFS_CLOCK_CONFIG:
				begin
					if (prot_ok)
					begin
						if (st_reg.w_strb[1])
							st_next.debug_run = st_reg.w_data[WDU_CLK_DEBUG_RUN_BIT];
						if (st_reg.w_strb[0])
						begin
							st_next.div_sel = st_reg.w_data[WDU_CLK_DIV_LSB +: 2];
							// an unfitted source keeps the old choice
							if (WDU_SRC_FITTED[st_reg.w_data[WDU_CLK_SRC_LSB +: 2]])
								st_next.src_sel = st_reg.w_data[WDU_CLK_SRC_LSB +: 2];
						end
					end
				end
				WDU_OFS_CONTROL:
				begin
					if (prot_ok)
					begin
						if (st_reg.w_strb[1])
							st_next.mode = st_reg.w_data[WDU_CTL_MODE_LSB +: 2];
						if (st_reg.w_strb[0])
							st_next.running = st_reg.w_data[3:0] != WDU_RUN_STOP;
						if (cnt_clear)
							st_next.stat_flag = 1'b0;
					end
				end
				WDU_OFS_COMPARE:
				begin
					if (prot_ok)
					begin
						if (st_reg.w_strb[0])
							st_next.cmp[7:0] = wval[7:0];
						if (st_reg.w_strb[1])
							st_next.cmp[9:8] = wval[9:8];
					end
				end
				default:
					st_next.bresp = WDU_RESP_SLVERR;
			endcase
		end
		if (st_reg.bvalid && s_axi_bready)
			st_next.bvalid = 1'b0;
		// read path: one read in flight
		if (s_axi_arvalid && !st_reg.rvalid)
		begin
			st_next.rvalid = 1'b1;
			st_next.rresp  = WDU_RESP_OKAY;
			st_next.rdata  = 32'h00000000;
			unique case (s_axi_araddr)
				WDU_OFS_CLOCK_CONFIG:
				begin
					st_next.rdata[WDU_CLK_DEBUG_RUN_BIT]        = st_reg.debug_run;
					st_next.rdata[WDU_CLK_DIV_LSB +: 2]     = st_reg.div_sel;
					st_next.rdata[WDU_CLK_SRC_LSB +: 2]     = st_reg.src_sel;
				end
				WDU_OFS_CONTROL:
				begin
					st_next.rdata[WDU_CTL_MODE_LSB +: 2]    = st_reg.mode;
					st_next.rdata[WDU_CTL_STAT_BIT]         = st_reg.stat_flag;
					// clear bit always reads zero
					st_next.rdata[WDU_CTL_RUN_LSB +: 4]     =
						st_reg.running ? WDU_RUN_READ_RUN : WDU_RUN_STOP;
				end
				WDU_OFS_COMPARE:
					st_next.rdata[9:0] = st_reg.cmp;
				WDU_OFS_PROTECTION:
					st_next.rdata[0] = st_reg.unlocked;
				default:
					st_next.rresp = WDU_RESP_SLVERR;
			endcase
		end
		if (st_reg.rvalid && s_axi_rready)
			st_next.rvalid = 1'b0;
		// match action; the event beats a same-cycle clear
		if (cnt_match)
		begin
			unique case (st_reg.mode)
				WDU_MODE_RESET:
					st_next.rst = 1'b1;
				WDU_MODE_NMI:
				begin
					st_next.nmi       = 1'b1;
					st_next.stat_flag = 1'b1;
				end
				WDU_MODE_ESCALATE:
				begin
					if (st_reg.stat_flag)
						st_next.rst = 1'b1;
					else
					begin
						st_next.nmi       = 1'b1;
						st_next.stat_flag = 1'b1;
					end
				end
				default:
				begin
					// reserved mode takes no action
				end
			endcase
		end
	end

	// state register; system reset restores documented values
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg     <= '0;
			st_reg.cmp <= WDU_CMP_RESET;
		end
		else
			st_reg <= st_next;
	end

	assign s_axi_awready      = !st_reg.aw_held;
	assign s_axi_wready       = !st_reg.w_held;
	assign s_axi_bvalid       = st_reg.bvalid;
	assign s_axi_bresp        = st_reg.bresp;
	assign s_axi_arready      = !st_reg.rvalid;
	assign s_axi_rvalid       = st_reg.rvalid;
	assign s_axi_rdata        = st_reg.rdata;
	assign s_axi_rresp        = st_reg.rresp;
	assign nmi_pulse          = st_reg.nmi;
	assign system_reset_pulse = st_reg.rst;

	a_nmi_sets_flag : assert property (@(posedge aclk) disable iff (!aresetn)
		nmi_pulse |-> st_reg.stat_flag) else $error("nmi without flag");
	a_reset_mode : assert property (@(posedge aclk) disable iff (!aresetn)
		cnt_match && st_reg.mode == WDU_MODE_RESET |=> system_reset_pulse && !nmi_pulse)
		else $error("reset mode missed reset");
	a_escalate : assert property (@(posedge aclk) disable iff (!aresetn)
		cnt_match && st_reg.mode == WDU_MODE_ESCALATE && st_reg.stat_flag
		|=> system_reset_pulse) else $error("no escalation");
	a_reserved_quiet : assert property (@(posedge aclk) disable iff (!aresetn)
		st_reg.mode == 2'h3 && cnt_match |=> !nmi_pulse && !system_reset_pulse)
		else $error("reserved mode acted");
	a_locked_stop : assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && !prot_ok |=> st_reg.running == $past(st_reg.running))
		else $error("locked write changed run");
	a_stop_no_tick : assert property (@(posedge aclk) disable iff (!aresetn)
		!st_reg.running ##1 !st_reg.running |-> !cnt_tick)
		else $error("tick while stopped");
	// checks the divider output itself, not the gate expression feeding it
	a_debug_gate : assert property (@(posedge aclk) disable iff (!aresetn)
		cpu_debug_mode && !st_reg.debug_run ##1 cpu_debug_mode && !st_reg.debug_run
		|-> !cnt_tick) else $error("tick while debug gated");
	a_clear_flag : assert property (@(posedge aclk) disable iff (!aresetn)
		cnt_clear && !cnt_match |=> !st_reg.stat_flag && cnt_value == 10'h000)
		else $error("clear kept flag");
	c_nmi : cover property (@(posedge aclk) nmi_pulse);
	c_reset : cover property (@(posedge aclk) system_reset_pulse);
	c_escalate : cover property (@(posedge aclk) nmi_pulse ##[1:1000] system_reset_pulse);
endmodule // wdu_top
`default_nettype wire

// [verification/wdu_top_tb.sv]
// Purpose: self-checking bench for the watchdog unit over its register bus
// Assumes: a source tick held high gives one tick per aclk cycle
// Notes:   bready and rready stay high throughout, which the bus permits
`timescale 1ns/10ps
`default_nettype none
module wdu_top_tb;
	import wdu_pkg::*;
	localparam int LIMIT = 80000; // ceiling on run length in cycles
	logic        aclk;      // 100 MHz bench clock
	logic        aresetn;   // sync reset, low active
	logic [3:0]  awaddr;    // write address
	logic        awvalid;   // write address valid
	logic        awready;   // write address ready
	logic [31:0] wdata;     // write data
	logic        wvalid;    // write data valid
	logic        wready;    // write data ready
	logic [1:0]  bresp;     // write response
	logic        bvalid;    // write response valid
	logic [3:0]  araddr;    // read address
	logic        arvalid;   // read address valid
	logic        arready;   // read address ready
	logic [31:0] rdata;     // read data
	logic [1:0]  rresp;     // read response
	logic        rvalid;    // read data valid
	logic [3:0]  tick_en;   // per source: ticks running
	logic        debug;     // cpu in debug mode
	logic        nmi;       // nmi event out
	logic        rst_ev;    // reset event out
	int          cyc;       // cycles since start
	int          n_nmi;     // nmi events seen
	int          n_rst;     // reset events seen
	int          err_count; // mismatches
	int          n_tests;   // comparisons made
	int          a;         // event count snapshot
	logic [31:0] w_tab [3]; // clock config per divider case
	int          e_tab [3]; // expected divided period per case

	wdu_top i_wdu_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1), .internal_oscillator_tick(tick_en[0]),
		.low_speed_crystal_tick(tick_en[1]), .high_speed_oscillator_tick(tick_en[2]),
		.external_clock_input_tick(tick_en[3]), .cpu_debug_mode(debug),
		.nmi_pulse(nmi), .system_reset_pulse(rst_ev));

	always #5 aclk = ~aclk;

	// count on the falling edge so the main sequence never races the counters
	always @(negedge aclk)
	begin
		cyc++;
		if (nmi === 1'b1) n_nmi++;
		if (rst_ev === 1'b1) n_rst++;
		if (cyc == LIMIT)
		begin
			err_count++; // hang cut short
			finish_test();
		end
	end

	task automatic finish_test();
		if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_num(input string nm, input int e, input int g);
		n_tests++;
		if (g != e)
		begin
			err_count++;
			$display("Error %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	// both halves offered at once, each released at its own handshake edge
	task automatic axw(input logic [3:0] ad, input logic [31:0] d);
		bit aw_ok;
		bit w_ok;
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		aw_ok = 0;
		w_ok = 0;
		// no local cap: only the bench timeout may end a wait
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin awvalid <= 1'b0; aw_ok = 1; end
			if (wvalid && wready === 1'b1) begin wvalid <= 1'b0; w_ok = 1; end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		chk_word("bresp", {30'h0, WDU_RESP_OKAY}, {30'h0, bresp});
	endtask

	// read one register and compare the word and the response
	task automatic rd_chk(input logic [3:0] ad, input logic [31:0] e, input string nm);
		araddr <= ad;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		chk_word("rresp", {30'h0, WDU_RESP_OKAY}, {30'h0, rresp});
		chk_word(nm, e, rdata);
	endtask

	// unbounded wait for the next event of one kind; only the bench timeout ends it
	task automatic wait_ev(input bit r);
		do @(posedge aclk); while ((r ? rst_ev : nmi) !== 1'b1);
	endtask

	// cycles between two successive events must equal the period
	task automatic gap(input bit r, input int e, input string nm);
		int t0;
		wait_ev(r);
		t0 = cyc;
		wait_ev(r);
		chk_num(nm, e, cyc - t0);
	endtask

	// no event of either kind over n cycles
	task automatic quiet(input int n, input string nm);
		int b;
		b = n_nmi + n_rst;
		repeat (n) @(posedge aclk);
		chk_num(nm, 0, n_nmi + n_rst - b);
	endtask

	initial
	begin
		aclk = 0; aresetn = 0; awaddr = 0; awvalid = 0; wdata = 0; wvalid = 0;
		araddr = 0; arvalid = 0; tick_en = 4'hf; debug = 0;
		cyc = 0; n_nmi = 0; n_rst = 0; err_count = 0; n_tests = 0;
		w_tab = '{32'h1, 32'h0, 32'h32};
		e_tab = '{128, 2048, 16384};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// reset values
		rd_chk(WDU_OFS_CLOCK_CONFIG, 32'h0, "clock config");
		rd_chk(WDU_OFS_CONTROL, 32'h0a, "control");
		rd_chk(WDU_OFS_COMPARE, 32'h3ff, "compare");
		rd_chk(WDU_OFS_PROTECTION, 32'h0, "protection");
		// locked writes are dropped
		axw(WDU_OFS_COMPARE, 32'h5);
		rd_chk(WDU_OFS_COMPARE, 32'h3ff, "compare locked");
		axw(WDU_OFS_CONTROL, 32'h210);
		rd_chk(WDU_OFS_CONTROL, 32'h0a, "control locked");
		axw(WDU_OFS_PROTECTION, 32'h96);
		rd_chk(WDU_OFS_PROTECTION, 32'h1, "protection open");
		// external source at 1/1, compare 3, nmi mode
		axw(WDU_OFS_CLOCK_CONFIG, 32'h3);
		axw(WDU_OFS_COMPARE, 32'h3);
		axw(WDU_OFS_CONTROL, 32'h210);
		gap(0, 4, "nmi period");
		rd_chk(WDU_OFS_CONTROL, 32'h300, "flag set running");
		// stop, then clear the flag; bit 8 cannot be written
		axw(WDU_OFS_CONTROL, 32'h20a);
		// a tick already in the divider when the stop lands may still match
		repeat (3) @(posedge aclk);
		quiet(40, "stopped");
		rd_chk(WDU_OFS_CONTROL, 32'h30a, "flag held stopped");
		axw(WDU_OFS_CONTROL, 32'h31a);
		rd_chk(WDU_OFS_CONTROL, 32'h20a, "flag cleared");
		// regular clearing keeps a longer period from expiring
		axw(WDU_OFS_COMPARE, 32'hf);
		a = n_nmi;
		repeat (8) axw(WDU_OFS_CONTROL, 32'h210);
		chk_num("serviced nmi count", 0, n_nmi - a);
		gap(0, 16, "period 16");
		// reset, reserved and escalate modes in turn
		axw(WDU_OFS_COMPARE, 32'h3);
		axw(WDU_OFS_CONTROL, 32'h010);
		a = n_nmi;
		gap(1, 4, "reset period");
		chk_num("nmi in reset mode", 0, n_nmi - a);
		axw(WDU_OFS_CONTROL, 32'h610);
		quiet(40, "reserved mode");
		axw(WDU_OFS_CONTROL, 32'h410);
		a = n_nmi;
		wait_ev(1);
		chk_num("nmi before escalation", 1, n_nmi - a);
		// debug gating follows the debug run bit
		axw(WDU_OFS_CONTROL, 32'h210);
		debug <= 1'b1;
		quiet(40, "debug gated");
		axw(WDU_OFS_CLOCK_CONFIG, 32'h103);
		gap(0, 4, "debug run");
		debug <= 1'b0;
		// a stopped source stops the count, a running one keeps it going
		tick_en <= 4'h0;
		quiet(40, "source stopped");
		tick_en <= 4'hf;
		gap(0, 4, "source resumed");
		// divider ratios for the other sources, one tick per match
		axw(WDU_OFS_COMPARE, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			axw(WDU_OFS_CLOCK_CONFIG, w_tab[i]);
			axw(WDU_OFS_CONTROL, 32'h210);
			gap(0, e_tab[i], "divided period");
		end
		// any other key closes the protected fields again
		axw(WDU_OFS_PROTECTION, 32'h0);
		rd_chk(WDU_OFS_PROTECTION, 32'h0, "protection closed");
		axw(WDU_OFS_COMPARE, 32'h7);
		rd_chk(WDU_OFS_COMPARE, 32'h0, "compare relocked");
		finish_test();
	end
endmodule // wdu_top_tb
`default_nettype wire
